// >>> core/adrs_reset_sequencer.v
// Reset, start-up lockout, PLL settle and power-stage reset logic
`timescale 1ns/1ps
`include "adrs_defines.vh"
module adrs_reset_sequencer #(
    parameter INIT_CYCLES = `ADRS_INIT_CYCLES,
    parameter PLL_CYCLES = `ADRS_PLL_CYCLES,
    parameter CNT_W = 20
) (
    input wire clk_i,              // 40 MHz system clock
    input wire sys_rst_i,          // Synchronous reset, active high
    input wire hw_reset_n_i,       // Hardware reset pin, active low
    input wire reg_wr_i,           // Register write strobe
    input wire reg_rd_i,           // Register read strobe
    input wire [7:0] reg_addr_i,   // Register address within current page
    input wire [7:0] reg_wdata_i,  // Register write data
    input wire pll_power_up_i,     // PLL power-up command level
    input wire [3:0] ocp_trip_i,   // Overcurrent trips: hp left, hp right, spk left, spk right
    output reg [7:0] reg_rdata_o,  // Register read data
    output reg init_busy_o,        // Memory initialisation running
    output reg core_reset_o,       // Reset to all control registers of the device
    output reg clocks_ready_o,     // Derived clocks may reach processing logic
    output reg [3:0] stage_shutdown_o, // Latched overcurrent shutdown per stage
    output reg [3:0] stage_reset_o // One-cycle power-stage reset pulses
);
    // Overview of the sequencing:
    // - A low pin or a write of the soft reset bit restarts the device exactly as the system reset does,
    //   except that read data is left alone and a trip in that cycle still sets its shutdown latch.
    // - The lockout counter then runs INIT_CYCLES clocks from release; the host must leave the
    //   coefficient buffers and block power-up alone until the busy flag drops.
    // - The PLL timer only runs while the power-up command is held; dropping it gates the clocks at once.
    // - Each output stage has a shutdown latch that a trip sets and that its stage reset,
    //   a full reset or the system reset clears; a trip wins over a clear in the same cycle except under the system reset.
    // - Reset bits are strobes, not storage; the soft reset bit reads zero, the stage reset bits read back the shutdown latches.
    // Limitation: the lockout and settle lengths are counted in system clocks, so INIT_CYCLES and
    // PLL_CYCLES must be rescaled together with the clock frequency, and CNT_W must hold the larger.
    // Trade-off: one counter per timer costs a few flops but keeps both timers independent.

    localparam ST_IDLE = 2'd0;
    localparam ST_INIT = 2'd1;
    reg [1:0] state;
    reg [7:0] page;
    reg [CNT_W-1:0] init_cnt;
    reg [CNT_W-1:0] pll_cnt;
    reg [1:0] next_state;
    reg [CNT_W-1:0] next_init_cnt;
    reg next_busy;
    reg [CNT_W-1:0] next_pll_cnt;
    reg next_clocks_ready;
    reg [3:0] next_shutdown;
    reg [7:0] next_page;
    reg [7:0] next_rdata;
    wire full_reset;
    wire sel_p0;
    wire sel_p1;
    wire soft_hit;
    wire [3:0] stage_hit;

    // Decode a write to a register on a given page
    function wr_hit;
        input [7:0] pg;
        input [7:0] addr;
        input [7:0] want_pg;
        input [7:0] want_addr;
        begin
            wr_hit = (pg == want_pg) && (addr == want_addr);
        end
    endfunction

    // Readback of one stage pair: left stage in bit 7, right stage in bit 6
    function [7:0] pair_rb;
        input [1:0] sd;
        begin
            pair_rb = {sd[0], sd[1], 6'h00};
        end
    endfunction

    assign sel_p0 = (page == `ADRS_PAGE_0);
    assign sel_p1 = (page == `ADRS_PAGE_1);
    assign soft_hit = reg_wr_i && wr_hit(page, reg_addr_i, `ADRS_PAGE_0, `ADRS_SOFT_RESET_ADDR)
        && reg_wdata_i[`ADRS_SOFT_RESET_BIT];
    // Stage reset requests from register writes
    assign stage_hit[0] = reg_wr_i && wr_hit(page, reg_addr_i, `ADRS_PAGE_1, `ADRS_HP_STAGE_RESET_ADDR)
        && reg_wdata_i[`ADRS_LEFT_STAGE_BIT];
    assign stage_hit[1] = reg_wr_i && wr_hit(page, reg_addr_i, `ADRS_PAGE_1, `ADRS_HP_STAGE_RESET_ADDR)
        && reg_wdata_i[`ADRS_RIGHT_STAGE_BIT];
    assign stage_hit[2] = reg_wr_i && wr_hit(page, reg_addr_i, `ADRS_PAGE_1, `ADRS_SPK_STAGE_RESET_ADDR)
        && reg_wdata_i[`ADRS_LEFT_STAGE_BIT];
    assign stage_hit[3] = reg_wr_i && wr_hit(page, reg_addr_i, `ADRS_PAGE_1, `ADRS_SPK_STAGE_RESET_ADDR)
        && reg_wdata_i[`ADRS_RIGHT_STAGE_BIT];

    // Pin low or soft reset bit both restart the device the same way
    assign full_reset = sys_rst_i || !hw_reset_n_i || soft_hit;

    // No release-edge detector: holding the lockout counter clear while the pin is low already
    // starts the lockout at release, and it cannot see a false edge after the system reset

    // Reset pulse fans out to the rest of the device; all blocks come up powered down
    // Registered so the fan-out sees a clean level rather than the raw pin or a decode glitch
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            core_reset_o <= 1'b1;
        end else begin
            core_reset_o <= !hw_reset_n_i || soft_hit;
        end
    end

    // Page pointer next value; address 0x00 selects the page from every page
    always @* begin
        next_page = page;
        if (reg_wr_i && reg_addr_i == `ADRS_PAGE_SEL_ADDR) begin
            next_page = reg_wdata_i;
        end
    end

    // Page pointer; stays put across power-down so settings are kept
    always @(posedge clk_i) begin
        if (full_reset) begin
            page <= `ADRS_RESET_VALUE;
        end else begin
            page <= next_page;
        end
    end

    // Initialisation lockout registers, held at the start while any reset is active
    always @(posedge clk_i) begin
        if (full_reset) begin
            state <= ST_INIT;
            init_cnt <= {CNT_W{1'b0}};
            init_busy_o <= 1'b1;
        end else begin
            state <= next_state;
            init_cnt <= next_init_cnt;
            init_busy_o <= next_busy;
        end
    end

    // Lockout next state; counting from release keeps the bound at 1 ms even for a long pin low
    always @* begin
        next_state = state;
        next_init_cnt = init_cnt;
        next_busy = init_busy_o;
        case (state)
            ST_INIT: begin
                if (init_cnt == INIT_CYCLES[CNT_W-1:0] - 1'b1) begin
                    next_state = ST_IDLE;
                    next_busy = 1'b0;
                end else begin
                    next_init_cnt = init_cnt + 1'b1;
                end
            end
            ST_IDLE: begin
                next_busy = 1'b0;
            end
            default: begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    // PLL settle next values; the count freezes at its end so the ready flag cannot wrap
    always @* begin
        next_pll_cnt = pll_cnt;
        next_clocks_ready = clocks_ready_o;
        if (pll_cnt == PLL_CYCLES[CNT_W-1:0] - 1'b1) begin
            next_clocks_ready = 1'b1;
        end else begin
            next_pll_cnt = pll_cnt + 1'b1;
        end
    end

    // PLL settle timer; clocks stay gated until it expires, and dropping the command gates them at once
    always @(posedge clk_i) begin
        if (full_reset || !pll_power_up_i) begin
            pll_cnt <= {CNT_W{1'b0}};
            clocks_ready_o <= 1'b0;
        end else begin
            pll_cnt <= next_pll_cnt;
            clocks_ready_o <= next_clocks_ready;
        end
    end

    // Shutdown next value: a stage reset clears, a trip in the same cycle sets again, so set wins
    always @* begin
        next_shutdown = (stage_shutdown_o & ~stage_hit) | ocp_trip_i;
    end

    // Overcurrent latch per stage; a pin or soft reset clears it, but a trip in that cycle still latches
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            stage_shutdown_o <= 4'h0;
            stage_reset_o <= 4'h0;
        end else if (full_reset) begin
            stage_shutdown_o <= ocp_trip_i;
            stage_reset_o <= 4'h0;
        end else begin
            stage_reset_o <= stage_hit;
            stage_shutdown_o <= next_shutdown;
        end
    end

    // Read decode: soft reset bit self-clears and reads zero, stage reset bits read the shutdown latches; busy in soft reset reg bit 7
    always @* begin
        next_rdata = 8'h00;
        if (reg_addr_i == `ADRS_PAGE_SEL_ADDR) begin
            next_rdata = page;
        end else if (sel_p0 && reg_addr_i == `ADRS_SOFT_RESET_ADDR) begin
            next_rdata = {init_busy_o, 7'h00};
        end else if (sel_p1 && reg_addr_i == `ADRS_HP_STAGE_RESET_ADDR) begin
            next_rdata = pair_rb(stage_shutdown_o[1:0]);
        end else if (sel_p1 && reg_addr_i == `ADRS_SPK_STAGE_RESET_ADDR) begin
            next_rdata = pair_rb(stage_shutdown_o[3:2]);
        end
    end

    // Read data register; holds until the next read so the host may sample late
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end
endmodule

// >>> core/adrs_defines.vh
// Register map, field positions and timing constants of the reset sequencer
`ifndef ADRS_DEFINES_VH
`define ADRS_DEFINES_VH
`define ADRS_PAGE_0 8'h00
`define ADRS_PAGE_1 8'h01
`define ADRS_PAGE_SEL_ADDR 8'h00
`define ADRS_SOFT_RESET_ADDR 8'h01
`define ADRS_HP_STAGE_RESET_ADDR 8'h1f
`define ADRS_SPK_STAGE_RESET_ADDR 8'h20
`define ADRS_SOFT_RESET_BIT 0
`define ADRS_LEFT_STAGE_BIT 7
`define ADRS_RIGHT_STAGE_BIT 6
`define ADRS_RESET_VALUE 8'h00
`define ADRS_CLK_HZ 40000000
`define ADRS_INIT_TIME_US 1000
`define ADRS_PLL_TIME_US 10000
`define ADRS_INIT_CYCLES ((`ADRS_CLK_HZ / 1000000) * `ADRS_INIT_TIME_US)
`define ADRS_PLL_CYCLES ((`ADRS_CLK_HZ / 1000000) * `ADRS_PLL_TIME_US)
`endif

// >>> bench/adrs_asserts.sv
// Port checker for the reset sequencer
`timescale 1ns/1ps
module adrs_asserts #(parameter INIT_CYCLES = 20, parameter PLL_CYCLES = 50) (
    input clk_i, sys_rst_i, hw_reset_n_i, reg_wr_i, reg_rd_i, pll_power_up_i, // Controls
    input [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, // Bus
    input init_busy_o, core_reset_o, clocks_ready_o, // Status
    input [3:0] ocp_trip_i, stage_shutdown_o, stage_reset_o); // Stages
    reg [7:0] pg = 8'h00;
    reg [19:0] bc = 20'h0, pc = 20'h0;
    reg [3:0] ex = 4'h0;
    wire [1:0] lr = {reg_wdata_i[6], reg_wdata_i[7]} & {2{reg_wr_i && pg == 8'h01}};
    // Page shadow, expected pulses, run lengths; a core reset returns the page to 0
    always @(posedge clk_i) begin
        pg <= (sys_rst_i || core_reset_o) ? 8'h00 : (reg_wr_i && reg_addr_i == 8'h00) ? reg_wdata_i : pg;
        ex <= {reg_addr_i == 8'h20 ? lr : 2'b00, reg_addr_i == 8'h1f ? lr : 2'b00};
        bc <= (sys_rst_i || !init_busy_o) ? 20'h0 : bc + 20'h1;
        pc <= (sys_rst_i || !pll_power_up_i) ? 20'h0 : pc + 20'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_pin; !hw_reset_n_i |=> core_reset_o && init_busy_o; endproperty
    a_pin: assert property (p_pin) else $error("pin reset lost");
    property p_soft; reg_wr_i && pg == 8'h00 && reg_addr_i == 8'h01 && reg_wdata_i[0] |=> core_reset_o ##1 !core_reset_o; endproperty
    a_soft: assert property (p_soft) else $error("soft reset lost");
    property p_busy; bc <= INIT_CYCLES + 2; endproperty
    a_busy: assert property (p_busy) else $error("init too long");
    property p_hp; stage_reset_o[1:0] == ex[1:0]; endproperty
    a_hp: assert property (p_hp) else $error("headphone pulse");
    property p_sp; stage_reset_o[3:2] == ex[3:2]; endproperty
    a_sp: assert property (p_sp) else $error("speaker pulse");
    property p_clr; (stage_reset_o & stage_shutdown_o & ~$past(ocp_trip_i)) == 4'h0; endproperty
    a_clr: assert property (p_clr) else $error("shutdown kept");
    property p_trip; (stage_shutdown_o & $past(ocp_trip_i)) == $past(ocp_trip_i); endproperty
    a_trip: assert property (p_trip) else $error("trip not latched");
    property p_pll; clocks_ready_o ? pc >= PLL_CYCLES - 1 : pc < PLL_CYCLES + 2; endproperty
    a_pll: assert property (p_pll) else $error("pll settle time");
    c_soft: cover property (core_reset_o && hw_reset_n_i);
    c_stage: cover property (stage_reset_o != 4'h0);
    c_pll: cover property ($rose(clocks_ready_o));
endmodule
bind adrs_reset_sequencer adrs_asserts #(.INIT_CYCLES(INIT_CYCLES), .PLL_CYCLES(PLL_CYCLES)) u_chk (.*);

// >>> bench/adrs_host.sv
// Host model on the control port
`timescale 1ns/1ps
module adrs_host (
    input clk_i, init_busy_o, // Clock, init flag
    input [7:0] reg_rdata_o, // Read data
    output reg hw_reset_n_i = 1'b0, // Low while supply ramps
    output reg reg_wr_i = 1'b0, reg_rd_i = 1'b0, // Strobes
    output reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00); // Address, data
    initial #50 hw_reset_n_i = 1'b1;
    // One strobe cycle; released lines go inverted so stale data never looks valid
    task xfer(input wr, input [7:0] a, input [7:0] d, output [7:0] q); begin
        @(negedge clk_i) {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {wr, !wr, a, d};
        @(negedge clk_i) {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {2'b00, ~a, ~d};
        q = reg_rdata_o;
    end endtask
    // Power-up and coefficient traffic waits for init to end
    task idle(output integer n); begin
        for (n = 0; n < 99 && init_busy_o !== 1'b0; n = n + 1) @(negedge clk_i);
    end endtask
    // One cycle low, 25 ns, past the minimum
    task pin; begin
        @(negedge clk_i) hw_reset_n_i = 1'b0;
        @(negedge clk_i) hw_reset_n_i = 1'b1;
    end endtask
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module testbench;
    reg clk_i = 1'b0, sys_rst_i = 1'b1, pll_power_up_i = 1'b0;
    reg [3:0] ocp_trip_i = 4'h0, sd = 4'h0;
    wire hw_reset_n_i, reg_wr_i, reg_rd_i, init_busy_o, core_reset_o, clocks_ready_o;
    wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    wire [3:0] stage_shutdown_o, stage_reset_o;
    integer fails = 0, comparisons = 0, i, n;
    reg [7:0] r = 8'h05, q;
    adrs_reset_sequencer #(.INIT_CYCLES(20), .PLL_CYCLES(50)) u_adrs_reset_sequencer (.*);
    adrs_host u_adrs_host (.*);
    function [7:0] lfsr(input [7:0] s); lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]}; endfunction
    // Readback: left shutdown in bit 7, right in bit 6
    function [7:0] rb(input [1:0] s); rb = {s[0], s[1], 6'h00}; endfunction
    task chk(input [7:0] seen, input [7:0] exp); begin
        comparisons = comparisons + 1;
        if (seen !== exp) $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        if (seen !== exp) fails = fails + 1;
    end endtask
    task report_and_stop; begin
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end endtask
    initial forever #12.5 clk_i = ~clk_i;
    // Run is about 200 cycles; allow ten times that
    initial begin
        #50000 fails = fails + 1;
        report_and_stop;
    end
    initial begin
        #75 sys_rst_i = 1'b0;
        u_adrs_host.idle(n);
        u_adrs_host.pin;
        chk(init_busy_o, 1);
        u_adrs_host.idle(n);
        chk(n > 15 && n < 23, 1);
        u_adrs_host.xfer(1, 8'h00, 8'h01, q);
        u_adrs_host.xfer(0, 8'h00, 8'h00, q);
        chk(q, 8'h01);
        u_adrs_host.xfer(0, 8'h1f, 8'h00, q);
        chk(q, 8'h00);
        u_adrs_host.xfer(0, 8'h55, 8'h00, q);
        chk(q, 8'h00);
        $display("reset test done");
        // Random trips, then random stage resets on alternating registers
        for (i = 0; i < 12; i = i + 1) begin
            r = lfsr(r);
            @(negedge clk_i) ocp_trip_i = r[3:0];
            @(negedge clk_i) ocp_trip_i = 4'h0;
            sd = sd | r[3:0];
            chk(stage_shutdown_o, sd);
            u_adrs_host.xfer(1, i[0] ? 8'h20 : 8'h1f, r, q);
            sd = sd & ~(i[0] ? {r[6], r[7], 2'b00} : {2'b00, r[6], r[7]});
            u_adrs_host.xfer(0, i[0] ? 8'h20 : 8'h1f, 8'h00, q);
            chk(q, i[0] ? rb(sd[3:2]) : rb(sd[1:0]));
        end
        // A trip in the write cycle beats the stage reset
        fork
            u_adrs_host.xfer(1, 8'h1f, 8'h80, q);
            @(negedge clk_i) ocp_trip_i = 4'h1;
        join
        chk(stage_reset_o, 4'h1);
        ocp_trip_i = 4'h0;
        chk(stage_shutdown_o[0], 1);
        pll_power_up_i = 1'b1;
        repeat (46) @(negedge clk_i);
        chk(clocks_ready_o, 0);
        repeat (6) @(negedge clk_i);
        chk(clocks_ready_o, 1);
        pll_power_up_i = 1'b0;
        $display("stage and pll tests done");
        u_adrs_host.xfer(1, 8'h00, 8'h00, q);
        u_adrs_host.xfer(1, 8'h01, 8'h01, q);
        chk(core_reset_o, 1);
        chk({init_busy_o, stage_shutdown_o}, 5'h10);
        u_adrs_host.xfer(0, 8'h01, 8'h00, q);
        chk(q, 8'h80);
        u_adrs_host.idle(n);
        chk(n > 10 && n < 22, 1);
        $display("soft reset test done");
        report_and_stop;
    end
endmodule
